//--- pkg/tmp_pkg.sv
// package of constants and types for the timer mode/polarity/prescale block
// assumes a single 10 MHz clock domain and synchronous active-high reset
package tmp_pkg;

	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;

	// ****************************************
	// register map
	// ****************************************
	localparam logic [3:0] ADDR_CTL1   = 4'h0;
	localparam logic [3:0] ADDR_CTL0   = 4'h1;
	localparam logic [3:0] ADDR_CTL2   = 4'h2;
	localparam logic [3:0] ADDR_RELOAD = 4'h3;
	localparam logic [3:0] ADDR_CAP0H  = 4'h4;
	localparam logic [3:0] ADDR_CAP0L  = 4'h5;
	localparam logic [3:0] ADDR_CAP1H  = 4'h6;
	localparam logic [3:0] ADDR_CAP1L  = 4'h7;
	localparam logic [3:0] ADDR_STAT   = 4'h8;
	localparam logic [3:0] ADDR_MASK   = 4'h9;

	// control one fields
	localparam int CTL1_EN_BIT  = 7;
	localparam int CTL1_POL_BIT = 6;
	localparam int CTL1_PRE_HI  = 5;
	localparam int CTL1_PRE_LO  = 3;
	localparam int CTL1_MOD_HI  = 2;
	localparam int CTL1_MOD_LO  = 0;
	// control zero: mode top bit
	localparam int CTL0_MODE3_BIT = 7;
	// control two fields
	localparam int CTL2_BOTH_BIT = 4;
	localparam int CTL2_OCTL_BIT = 2;

	localparam logic [7:0] CTL_RESET    = 8'h00;
	localparam logic [7:0] RELOAD_RESET = 8'hFF;
	localparam logic [7:0] ZERO8        = 8'h00;

	// status / mask bits
	localparam int ST_CAP0 = 0;
	localparam int ST_CAP1 = 1;
	localparam int ST_RELD = 2;
	localparam int ST_RSVD = 3;
	localparam int ST_W    = 4;

	// ****************************************
	// operating modes
	// ****************************************
	typedef enum logic [3:0] {
		MODE_ONESHOT     = 4'h0,
		MODE_CONTINUOUS  = 4'h1,
		MODE_COUNTER     = 4'h2,
		MODE_PWM_SINGLE  = 4'h3,
		MODE_CAPTURE     = 4'h4,
		MODE_COMPARE     = 4'h5,
		MODE_GATED       = 4'h6,
		MODE_CAP_COMPARE = 4'h7,
		MODE_PWM_DUAL    = 4'h8,
		MODE_CAP_RESTART = 4'h9,
		MODE_DUAL_TRIG   = 4'hA,
		MODE_TRIG_ONE    = 4'hB,
		MODE_CMP_COUNTER = 4'hC,
		MODE_DEMOD       = 4'hD,
		MODE_RSVD_E      = 4'hE,
		MODE_RSVD_F      = 4'hF
	} tmp_mode_t;

	typedef enum logic [1:0] {
		RUN_IDLE,
		RUN_ARMED,
		RUN_COUNT
	} tmp_run_t;

	localparam int PRE_W   = 3;
	localparam int PRE_CNT = 7;
	localparam logic [PRE_CNT-1:0] PRE_ONE  = 7'h01;
	localparam logic [PRE_CNT-1:0] PRE_ZERO = 7'h00;
	localparam logic [15:0] CNT_ONE  = 16'h0001;
	localparam logic [15:0] CNT_ZERO = 16'h0000;

endpackage : tmp_pkg

//--- hdl/tmp_edge_sync.sv
// three-stage pin synchroniser with rise/fall detection
// assumes the pin is asynchronous to clock
module tmp_edge_sync (
	input  wire logic clock,
	input  wire logic sys_rst,
	input  wire logic pin,
	output logic      level,
	output logic      rise,
	output logic      fall
);
	import tmp_pkg::*;

	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic lvl;
		logic r;
		logic f;
	} tmp_sync_t;

	tmp_sync_t st_q;
	tmp_sync_t st_d;

	always_comb begin
		st_d    = st_q;
		st_d.s1 = pin;
		st_d.s2 = st_q.s1;
		st_d.s3 = st_q.s2;
		st_d.r  = 1'b0;
		st_d.f  = 1'b0;
		// accept a change only once stages two and three agree
		if (st_q.s2 == st_q.s3 && st_q.s3 != st_q.lvl) begin
			st_d.lvl = st_q.s3;
			st_d.r   = st_q.s3;
			st_d.f   = ~st_q.s3;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign level = st_q.lvl;
	assign rise  = st_q.r;
	assign fall  = st_q.f;

endmodule : tmp_edge_sync

//--- hdl/tmp_timer.sv
// timer mode decode, input/output polarity, prescaler and capture
// assumes one 10 MHz clock; timer input 0 arrives asynchronously on a pin
//
// What this block does
// - capture restart: capture on polarity-selected edge
// - comparator counter: idle output=polarity, toggle reload
// - triggered one-shots, output_control_select 0: polarity-selected start
// - triggered one-shots, output_control_select 1: rising start with polarity 0, no start with polarity 1
// - demod both-edge: any edge triggers, both capture
// - demod both-edge: rise->first, fall->second capture
// - demod pol 0: rise starts, rises capture first
// - demod pol 1: fall starts, rises capture first
// - prescale divides input clock by two^field
// - prescaler cleared whenever timer disabled
// - mode = control-zero top bit plus three bits
// - decode documented mode codes
module tmp_timer (
	input  wire logic                   clock,
	input  wire logic                   sys_rst,
	input  wire logic [tmp_pkg::ADDR_W-1:0] reg_addr,
	input  wire logic [tmp_pkg::DATA_W-1:0] reg_wdata,
	input  wire logic                   reg_wr,
	input  wire logic                   reg_rd,
	output logic      [tmp_pkg::DATA_W-1:0] reg_rdata,
	input  wire logic                   timer_in0,
	output logic                        timer_out,
	output logic                        timer_irq
);
	import tmp_pkg::*;

	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		logic [7:0]         ctl1;
		logic [7:0]         ctl0;
		logic [7:0]         ctl2;
		logic [15:0]        reload;
		logic [15:0]        cnt;
		logic [15:0]        cap0;
		logic [15:0]        cap1;
		logic [PRE_CNT-1:0] pre;
		tmp_run_t           run;
		logic               tout;
		logic [ST_W-1:0]    stat;
		logic [ST_W-1:0]    mask;
		logic [7:0]         rdata;
		logic               irq;
	} tmp_state_t;

	tmp_state_t st_q;
	tmp_state_t st_d;

	logic in_level;
	logic in_rise;
	logic in_fall;

	tmp_edge_sync u_sync (
		.clock   (clock),
		.sys_rst (sys_rst),
		.pin     (timer_in0),
		.level   (in_level),
		.rise    (in_rise),
		.fall    (in_fall)
	);

	// ****************************************
	// decode
	// ****************************************
	logic               enabled;
	logic               pol;
	logic               both;
	logic               octl;
	logic [PRE_W-1:0]   pre_sel;
	tmp_mode_t          mode;
	logic               pol_edge;
	logic               tick;
	logic [PRE_CNT-1:0] pre_mask;
	logic               start_ev;
	logic               cap0_ev;
	logic               cap1_ev;
	logic               reload_ev;
	logic               triggered;
	logic               rsvd_combo;
	logic [ST_W-1:0]    ev;

	always_comb begin
		enabled = st_q.ctl1[CTL1_EN_BIT];
		pol     = st_q.ctl1[CTL1_POL_BIT];
		both    = st_q.ctl2[CTL2_BOTH_BIT];
		octl    = st_q.ctl2[CTL2_OCTL_BIT];
		pre_sel = st_q.ctl1[CTL1_PRE_HI:CTL1_PRE_LO];
		mode    = tmp_mode_t'({st_q.ctl0[CTL0_MODE3_BIT],
			st_q.ctl1[CTL1_MOD_HI:CTL1_MOD_LO]});
		pol_edge = pol ? in_fall : in_rise;
		// divide by 2^field: tick when the low field bits of the counter are all ones
		pre_mask = (PRE_ONE << pre_sel) - PRE_ONE;
		tick     = ((st_q.pre & pre_mask) == pre_mask);
		start_ev   = 1'b0;
		cap0_ev    = 1'b0;
		cap1_ev    = 1'b0;
		triggered  = 1'b0;
		rsvd_combo = 1'b0;
		case (mode)
			MODE_CAP_RESTART: begin
				cap0_ev = pol_edge;
			end
			MODE_TRIG_ONE, MODE_DUAL_TRIG: begin
				triggered = 1'b1;
				if (!octl) begin
					start_ev = pol_edge;
				end else begin
					// polarity 1 reserved here; flagged and never triggers
					start_ev   = in_rise & ~pol;
					rsvd_combo = pol;
				end
			end
			MODE_DEMOD: begin
				triggered = 1'b1;
				if (both) begin
					start_ev = in_rise | in_fall;
					cap0_ev  = in_rise;
					cap1_ev  = in_fall;
				end else if (!pol) begin
					start_ev = in_rise;
					cap0_ev  = in_rise;
				end else begin
					start_ev = in_fall;
					cap0_ev  = in_rise;
				end
			end
			MODE_RSVD_E, MODE_RSVD_F: begin
				rsvd_combo = 1'b1;
			end
			default: begin
				triggered = 1'b0;
			end
		endcase
		reload_ev = (st_q.run == RUN_COUNT) && tick && (st_q.cnt == st_q.reload);
	end

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		st_d = st_q;
		ev   = '0;
		// register writes
		if (reg_wr) begin
			if (reg_addr == ADDR_CTL1) begin
				st_d.ctl1 = reg_wdata;
			end else if (reg_addr == ADDR_CTL0) begin
				st_d.ctl0 = reg_wdata;
			end else if (reg_addr == ADDR_CTL2) begin
				st_d.ctl2 = reg_wdata;
			end else if (reg_addr == ADDR_RELOAD) begin
				st_d.reload = {reg_wdata, reg_wdata};
			end else if (reg_addr == ADDR_MASK) begin
				st_d.mask = reg_wdata[ST_W-1:0];
			end
		end
		// run control and prescaler
		if (!enabled) begin
			st_d.pre  = PRE_ZERO;
			st_d.cnt  = CNT_ONE;
			st_d.run  = RUN_IDLE;
			st_d.tout = pol;
		end else begin
			st_d.pre = st_q.pre + PRE_ONE;
			case (st_q.run)
				RUN_IDLE: begin
					st_d.run = triggered ? RUN_ARMED : RUN_COUNT;
				end
				RUN_ARMED: begin
					if (start_ev) begin
						st_d.run = RUN_COUNT;
					end
				end
				default: begin
					if (tick) begin
						st_d.cnt = reload_ev ? CNT_ONE : st_q.cnt + CNT_ONE;
					end
					if (reload_ev) begin
						st_d.tout = ~st_q.tout;
						if (mode == MODE_TRIG_ONE || mode == MODE_DUAL_TRIG) begin
							st_d.run = RUN_ARMED;
						end
					end
				end
			endcase
		end
		// captures only once counting is under way
		if (enabled && st_q.run == RUN_COUNT) begin
			if (cap0_ev) begin
				st_d.cap0 = st_q.cnt;
			end
			if (cap1_ev) begin
				st_d.cap1 = st_q.cnt;
			end
		end
		ev[ST_CAP0] = enabled && st_q.run == RUN_COUNT && cap0_ev;
		ev[ST_CAP1] = enabled && st_q.run == RUN_COUNT && cap1_ev;
		ev[ST_RELD] = reload_ev;
		ev[ST_RSVD] = enabled && rsvd_combo;
		// write-one-to-clear, a new event wins over the clear
		if (reg_wr && reg_addr == ADDR_STAT) begin
			st_d.stat = st_q.stat & ~reg_wdata[ST_W-1:0];
		end
		st_d.stat = st_d.stat | ev;
		st_d.irq  = |(st_d.stat & st_d.mask);
		// read data one cycle after the strobe, zero otherwise
		st_d.rdata = ZERO8;
		if (reg_rd) begin
			if (reg_addr == ADDR_CTL1) begin
				st_d.rdata = st_q.ctl1;
			end else if (reg_addr == ADDR_CTL0) begin
				st_d.rdata = st_q.ctl0;
			end else if (reg_addr == ADDR_CTL2) begin
				st_d.rdata = st_q.ctl2;
			end else if (reg_addr == ADDR_RELOAD) begin
				st_d.rdata = st_q.reload[7:0];
			end else if (reg_addr == ADDR_CAP0H) begin
				st_d.rdata = st_q.cap0[15:8];
			end else if (reg_addr == ADDR_CAP0L) begin
				st_d.rdata = st_q.cap0[7:0];
			end else if (reg_addr == ADDR_CAP1H) begin
				st_d.rdata = st_q.cap1[15:8];
			end else if (reg_addr == ADDR_CAP1L) begin
				st_d.rdata = st_q.cap1[7:0];
			end else if (reg_addr == ADDR_STAT) begin
				st_d.rdata = {{(8-ST_W){1'b0}}, st_q.stat};
			end else if (reg_addr == ADDR_MASK) begin
				st_d.rdata = {{(8-ST_W){1'b0}}, st_q.mask};
			end
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			st_q        <= '0;
			st_q.reload <= {RELOAD_RESET, RELOAD_RESET};
			st_q.cnt    <= CNT_ONE;
			st_q.run    <= RUN_IDLE;
		end else begin
			st_q <= st_d;
		end
	end

	assign reg_rdata = st_q.rdata;
	assign timer_out = st_q.tout;
	assign timer_irq = st_q.irq;

	// ****************************************
	// checks
	// ****************************************
	a_idle_out_pol: assert property (@(posedge clock) disable iff (sys_rst)
		!st_q.ctl1[CTL1_EN_BIT] && !$past(st_q.ctl1[CTL1_EN_BIT])
		&& $stable(st_q.ctl1[CTL1_POL_BIT]) |-> timer_out == st_q.ctl1[CTL1_POL_BIT])
		else $error("output not at polarity while disabled");
	a_reload_toggle: assert property (@(posedge clock) disable iff (sys_rst)
		reload_ev && enabled |=> timer_out != $past(timer_out))
		else $error("output did not toggle on reload");
	a_pre_clear: assert property (@(posedge clock) disable iff (sys_rst)
		!enabled |=> st_q.pre == PRE_ZERO)
		else $error("prescaler not cleared");
	a_pre_div_one: assert property (@(posedge clock) disable iff (sys_rst)
		pre_sel == 3'h0 |-> tick)
		else $error("divide by one missing ticks");
	a_restart_cap: assert property (@(posedge clock) disable iff (sys_rst)
		mode == MODE_CAP_RESTART && enabled && st_q.run == RUN_COUNT
		&& (pol ? in_fall : in_rise) |=> st_q.cap0 == $past(st_q.cnt))
		else $error("capture restart edge missed");
	a_trig_start: assert property (@(posedge clock) disable iff (sys_rst)
		(mode == MODE_TRIG_ONE || mode == MODE_DUAL_TRIG) && !octl && enabled
		&& st_q.run == RUN_ARMED && (pol ? in_fall : in_rise) |=> st_q.run == RUN_COUNT)
		else $error("triggered start missed");
	a_rsvd_nostart: assert property (@(posedge clock) disable iff (sys_rst)
		(mode == MODE_TRIG_ONE || mode == MODE_DUAL_TRIG) && octl && pol
		&& st_q.run == RUN_ARMED |=> st_q.run != RUN_COUNT)
		else $error("reserved polarity started timer");
	a_demod_fall: assert property (@(posedge clock) disable iff (sys_rst)
		mode == MODE_DEMOD && both && enabled && st_q.run == RUN_COUNT && in_fall
		|=> st_q.cap1 == $past(st_q.cnt) && st_q.stat[ST_CAP1])
		else $error("falling capture missing");
	a_demod_pol1: assert property (@(posedge clock) disable iff (sys_rst)
		mode == MODE_DEMOD && !both && pol && st_q.run == RUN_ARMED && in_rise
		&& !in_fall |=> st_q.run == RUN_ARMED)
		else $error("demod started on wrong edge");
	a_irq_level: assert property (@(posedge clock) disable iff (sys_rst)
		timer_irq == |($past(st_d.stat) & $past(st_d.mask)))
		else $error("interrupt level wrong");

	// ****************************************
	// checks: start and capture edges
	// ****************************************
	// a polarity change in the same cycle as the edge is not covered here
	a_restart_hold: assert property (@(posedge clock) disable iff (sys_rst)
		mode == MODE_CAP_RESTART && enabled && !(pol ? in_fall : in_rise)
		|=> $stable(st_q.cap0))
		else $error("capture restart took wrong edge");
	a_demod_rise: assert property (@(posedge clock) disable iff (sys_rst)
		mode == MODE_DEMOD && both && enabled && st_q.run == RUN_COUNT && in_rise
		|=> st_q.cap0 == $past(st_q.cnt) && st_q.stat[ST_CAP0])
		else $error("rising capture missing");
	a_both_start: assert property (@(posedge clock) disable iff (sys_rst)
		mode == MODE_DEMOD && both && enabled && st_q.run == RUN_ARMED
		&& (in_rise || in_fall) |=> st_q.run == RUN_COUNT)
		else $error("both-edge start missed");
	a_demod_pol0: assert property (@(posedge clock) disable iff (sys_rst)
		mode == MODE_DEMOD && !both && !pol && enabled && st_q.run == RUN_ARMED
		&& in_rise |=> st_q.run == RUN_COUNT)
		else $error("demod rising start missed");
	a_demod_fall_start: assert property (@(posedge clock) disable iff (sys_rst)
		mode == MODE_DEMOD && !both && pol && enabled && st_q.run == RUN_ARMED
		&& in_fall |=> st_q.run == RUN_COUNT)
		else $error("demod falling start missed");
	a_trig_oc1_rise: assert property (@(posedge clock) disable iff (sys_rst)
		(mode == MODE_TRIG_ONE || mode == MODE_DUAL_TRIG) && octl && !pol && enabled
		&& st_q.run == RUN_ARMED && in_rise |=> st_q.run == RUN_COUNT)
		else $error("output control one start missed");

	// ****************************************
	// checks: prescaler, reserved codes, bus
	// ****************************************
	// above divide by one a tick never repeats on the next cycle
	a_tick_spacing: assert property (@(posedge clock) disable iff (sys_rst)
		enabled && tick && pre_sel != 3'h0 |=> !tick || pre_sel != $past(pre_sel))
		else $error("prescaler ticked too often");
	a_rsvd_flag: assert property (@(posedge clock) disable iff (sys_rst)
		enabled && (mode == MODE_RSVD_E || mode == MODE_RSVD_F) |=> st_q.stat[ST_RSVD])
		else $error("reserved mode not flagged");
	a_rdata_idle: assert property (@(posedge clock) disable iff (sys_rst)
		!reg_rd |=> reg_rdata == ZERO8)
		else $error("read data not zero without strobe");

endmodule : tmp_timer

//--- tb/tmp_timer_tb.sv
// self-checking bench for the timer mode, polarity and prescale block
// assumes the register map and status layout of tmp_pkg; one 10 MHz clock
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_fail++; \
	$display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module tmp_timer_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import tmp_pkg::*;

	logic              clock     = 1'b0;
	logic              sys_rst   = 1'b1;
	logic [ADDR_W-1:0] reg_addr  = 4'h0;
	logic [DATA_W-1:0] reg_wdata = 8'h00;
	logic              reg_wr    = 1'b0;
	logic              reg_rd    = 1'b0;
	logic [DATA_W-1:0] reg_rdata;
	logic              timer_in0 = 1'b0;
	logic              timer_out;
	logic              timer_irq;
	int                n_fail      = 0;
	int                check_count = 0;
	logic [4:0]        m;
	logic [7:0]        d;
	logic [15:0]       v;
	logic [3:0]        ra [6] = '{ADDR_CTL1, ADDR_CTL0, ADDR_CTL2, ADDR_STAT, ADDR_MASK, ADDR_RELOAD};
	logic [7:0]        rv [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF};

	tmp_timer dut (
		.clock     (clock),
		.sys_rst   (sys_rst),
		.reg_addr  (reg_addr),
		.reg_wdata (reg_wdata),
		.reg_wr    (reg_wr),
		.reg_rd    (reg_rd),
		.reg_rdata (reg_rdata),
		.timer_in0 (timer_in0),
		.timer_out (timer_out),
		.timer_irq (timer_irq)
	);

	always #50 clock = ~clock;

	// ****************************************
	// bus and pin tasks
	// ****************************************
	task automatic wr(input logic [3:0] a, input logic [7:0] dat);
		@(posedge clock);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= dat;
		@(posedge clock);
		reg_wr    <= 1'b0;
	endtask : wr

	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, output logic [7:0] dat);
		@(posedge clock);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_rd   <= 1'b0;
		#1 dat = reg_rdata;
	endtask : rd

	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
	endtask : cyc

	task automatic pin(input logic lv);
		@(posedge clock);
		timer_in0 <= lv;
	endtask : pin

	// disable, settle the pin while idle, clear status, then enable with c1
	task automatic cfg(input logic [7:0] c0, c2, c1, input logic idle);
		wr(ADDR_CTL1, 8'h00);
		pin(idle);
		wr(ADDR_CTL0, c0);
		wr(ADDR_CTL2, c2);
		cyc(8);
		wr(ADDR_STAT, 8'hFF);
		wr(ADDR_CTL1, c1);
	endtask : cfg

	// four pin toggles; byte k of ex is the capture status after toggle k, FF = skip
	task automatic seq(input logic [3:0] md, input logic both, pol, idle, input logic [31:0] ex);
		logic lv;
		logic [7:0] s;
		lv = idle;
		cfg({md[3], 7'h00}, both ? 8'h10 : 8'h00, {1'b1, pol, 3'b111, md[2:0]}, idle);
		for (int k = 0; k < 4; k++) begin
			cyc(40);
			lv = ~lv;
			pin(lv);
			cyc(20);
			rd(ADDR_STAT, s);
			if (ex[8*k +: 8] != 8'hFF) `CHK("capture status", ex[8*k +: 8], s & 8'h03)
			wr(ADDR_STAT, 8'hFF);
		end
	endtask : seq

	// capture restart mode, rising edge t cycles after enable
	task automatic capv(input logic [2:0] p, input int t, output logic [15:0] val);
		cfg(8'h80, 8'h00, {1'b1, 1'b0, p, 3'b001}, 1'b0);
		cyc(t);
		pin(1'b1);
		cyc(20);
		rd(ADDR_CAP0H, val[15:8]);
		rd(ADDR_CAP0L, val[7:0]);
	endtask : capv

	// wrong edge first must not start; right edge starts and reaches reload
	task automatic trig(input logic [3:0] md, input logic octl, pol);
		logic [7:0] s;
		cfg({md[3], 7'h00}, octl ? 8'h04 : 8'h00, {1'b1, pol, 3'b000, md[2:0]}, ~pol);
		cyc(40);
		pin(pol);
		cyc(400);
		rd(ADDR_STAT, s);
		`CHK("reload before start", 1'b0, s[ST_RELD])
		pin(~pol);
		cyc(400);
		rd(ADDR_STAT, s);
		`CHK("reload after start", 1'b1, s[ST_RELD])
	endtask : trig

	task automatic complete_run();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : complete_run

	// ****************************************
	// watchdog
	// ****************************************
	initial begin
		repeat (50000) @(posedge clock);
		n_fail++;
		complete_run();
	end

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		repeat (6) @(posedge clock);
		sys_rst <= 1'b0;
		#1 `CHK("out after reset", 1'b0, timer_out)
		`CHK("irq after reset", 1'b0, timer_irq)
		for (int i = 0; i < 6; i++) begin
			rd(ra[i], d);
			`CHK("reset value", rv[i], d)
		end
		wr(4'hF, 8'h5A);
		rd(4'hF, d);
		`CHK("unmapped read", 8'h00, d)

		// comparator counter: idle level, then toggles at reload 16'h0101
		wr(ADDR_RELOAD, 8'h01);
		cfg(8'h80, 8'h00, 8'h44, 1'b0);
		cyc(3);
		`CHK("idle out pol1", 1'b1, timer_out)
		wr(ADDR_CTL1, 8'h04);
		cyc(3);
		`CHK("idle out pol0", 1'b0, timer_out)
		wr(ADDR_CTL1, 8'h84);
		cyc(150);
		`CHK("out before reload", 1'b0, timer_out)
		cyc(200);
		`CHK("out after reload", 1'b1, timer_out)

		// every mode code; only E and F are reserved
		for (m = 5'h00; m < 5'h10; m++) begin
			cfg({m[3], 7'h00}, 8'h00, {1'b1, 1'b0, 3'b000, m[2:0]}, 1'b0);
			cyc(5);
			rd(ADDR_STAT, d);
			`CHK("reserved flag", m >= 5'h0E, d[ST_RSVD])
			rd(ADDR_CTL0, d);
			`CHK("mode top bit", m[3], d[CTL0_MODE3_BIT])
		end
		cyc(3);
		`CHK("irq masked", 1'b0, timer_irq)
		wr(ADDR_MASK, 8'h08);
		cyc(2);
		`CHK("irq raised", 1'b1, timer_irq)
		rd(ADDR_MASK, d);
		`CHK("mask readback", 8'h08, d)
		wr(ADDR_CTL1, 8'h00);
		wr(ADDR_STAT, 8'h08);
		cyc(2);
		`CHK("irq cleared", 1'b0, timer_irq)
		wr(ADDR_MASK, 8'h00);

		// output control 1 with polarity 1 is the reserved combination
		cfg(8'h80, 8'h04, 8'hC3, 1'b1);
		cyc(5);
		rd(ADDR_STAT, d);
		`CHK("reserved trigger", 1'b1, d[ST_RSVD])

		trig(4'hA, 1'b0, 1'b0);
		trig(4'hA, 1'b0, 1'b1);
		trig(4'hB, 1'b0, 1'b0);
		trig(4'hB, 1'b0, 1'b1);
		trig(4'hB, 1'b1, 1'b0);

		seq(4'h9, 1'b0, 1'b0, 1'b0, 32'h00010001);
		seq(4'h9, 1'b0, 1'b1, 1'b0, 32'h01000100);
		seq(4'hD, 1'b0, 1'b0, 1'b0, 32'h000100FF);
		seq(4'hD, 1'b0, 1'b1, 1'b1, 32'h010001FF);
		seq(4'hD, 1'b1, 1'b1, 1'b0, 32'h020102FF);

		for (m = 5'h00; m < 5'h08; m++) begin
			capv(m[2:0], 20 << m, v);
			`CHK("prescaled count", 1'b1, v >= 16'h0014 && v <= ((20 << m) + 10 >> m) + 2)
		end

		// a partial prescale period before disable must not carry over
		wr(ADDR_CTL1, 8'hBC);
		cyc(100);
		capv(3'b111, 100, v);
		`CHK("count after restart", 16'h0001, v)
		complete_run();
	end
endmodule : tmp_timer_tb
